// ---- hdl/ild_pkg.sv ----
// Constants, register map and types of the input level detector.
// Assumes one 20 MHz clock; the microport pins are owned by the top module.
package ild_pkg;
  // Data path widths
  localparam int MANT_W = 14; // Input mantissa width per port
  localparam int CMP_W = 10; // Compared upper mantissa bits
  localparam int DWELL_W = 20; // Dwell counter width
  localparam int CTRL_W = 5; // Gain range control width
  localparam int NUM_PORTS = 4; // Ports A, B (low half), C, D (high half)
  localparam int LAT_DEPTH = 8; // Programmable output delay taps
  localparam int LAT_W = 3; // Delay select width
  localparam int DATA_W = 8; // Microport data width
  localparam int EXT_ADDR_W = 3; // Microport external address width
  localparam int CAR_W = 8; // Channel address pointer width

  // Control field positions
  localparam int CTRL_POL_BIT = 4; // Indicator polarity
  localparam int CTRL_ILV_BIT = 3; // Interleaved input
  localparam int CTRL_LAT_MSB = 2; // Delay field top bit
  localparam int SLEEP_ACCESS_BIT = 5; // Input port register access

  // External microport addresses
  localparam logic [EXT_ADDR_W-1:0] EXT_DATA0 = 3'h0; // Bits 7..0, commits
  localparam logic [EXT_ADDR_W-1:0] EXT_DATA1 = 3'h1; // Bits 15..8
  localparam logic [EXT_ADDR_W-1:0] EXT_DATA2 = 3'h2; // Bits 19..16
  localparam logic [EXT_ADDR_W-1:0] EXT_SLEEP = 3'h3; // Sleep register
  localparam logic [EXT_ADDR_W-1:0] EXT_CAR = 3'h6; // Channel address pointer

  // Channel address map, one half
  localparam logic [CAR_W-1:0] LOWER_THRESHOLD_A = 8'h00;
  localparam logic [CAR_W-1:0] UPPER_THRESHOLD_A = 8'h01;
  localparam logic [CAR_W-1:0] DWELL_TIME_A = 8'h02;
  localparam logic [CAR_W-1:0] GAIN_RANGE_CTRL_A = 8'h03;
  localparam logic [CAR_W-1:0] LOWER_THRESHOLD_B = 8'h04;
  localparam logic [CAR_W-1:0] UPPER_THRESHOLD_B = 8'h05;
  localparam logic [CAR_W-1:0] DWELL_TIME_B = 8'h06;
  localparam logic [CAR_W-1:0] GAIN_RANGE_CTRL_B = 8'h07;
  localparam logic [CAR_W-1:0] NUM_LOCATIONS = 8'h08;
  localparam int PORT_SEL_BIT = 2; // Picks port A or B inside a half

  // Reset values
  localparam logic [CMP_W-1:0] THRESH_RST = 10'h000;
  localparam logic [DWELL_W-1:0] DWELL_RST = 20'h00000;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
  localparam logic [DWELL_W-1:0] DWELL_ONE = 20'h00001;

  // Detector states
  typedef enum logic [1:0] {
    ILD_IDLE,
    ILD_ARMED,
    ILD_DWELL
  } ild_state_t;
endpackage

// ---- hdl/ild_port_detector.sv ----
// One input port level detector: thresholds, dwell counter, routing, delay.
// Assumes the mantissa and input enable are already synchronised to clk_i.
`timescale 1ns/10ps
`default_nettype none
module ild_port_detector (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Sample and settings
  input wire logic [ild_pkg::CMP_W-1:0] mant_i,
  input wire logic [ild_pkg::CMP_W-1:0] lower_i,
  input wire logic [ild_pkg::CMP_W-1:0] upper_i,
  input wire logic [ild_pkg::DWELL_W-1:0] dwell_i,
  input wire logic [ild_pkg::CTRL_W-1:0] ctrl_i,
  input wire logic input_enable_i,
  // Indicator pins
  output logic ind_first_o,
  output logic ind_second_o
);
  import ild_pkg::*;

  ild_state_t state, next_state; // Detector state
  logic [DWELL_W-1:0] count, next_count; // Dwell counter
  logic hold_first, next_hold_first; // Interleaved sample-and-hold
  logic hold_second, next_hold_second;
  logic [1:0] dly [LAT_DEPTH]; // Delay line of both pins
  logic [1:0] next_dly [LAT_DEPTH];
  logic [1:0] raw; // Undelayed pin levels
  logic lower_met; // At or below lower threshold
  logic upper_met; // At or above upper threshold
  logic enabled; // Dwell of zero disables all
  logic active; // Indication before routing
  logic [LAT_W-1:0] lat; // Selected delay tap

  assign lower_met = (mant_i <= lower_i);
  assign upper_met = (mant_i >= upper_i);
  assign enabled = (dwell_i != DWELL_RST);
  assign active = (state != ILD_IDLE);
  assign lat = ctrl_i[CTRL_LAT_MSB:0];

  // Threshold sequencing and dwell count
  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      ILD_IDLE: begin
        // Counter stays idle until an upper excursion
        next_count = DWELL_RST;
        if (enabled && upper_met) begin
          next_state = ILD_ARMED;
        end
      end
      ILD_ARMED: begin
        if (!enabled) begin
          next_state = ILD_IDLE;
        end else if (!upper_met && lower_met) begin
          // Lower met after upper excursion: load
          next_state = ILD_DWELL;
          next_count = dwell_i;
        end else begin
          next_count = dwell_i;
        end
      end
      ILD_DWELL: begin
        if (!enabled) begin
          next_state = ILD_IDLE;
        end else if (!lower_met) begin
          // Rise above lower: reload and wait for the fall
          next_state = ILD_ARMED;
          next_count = dwell_i;
        end else if (count <= DWELL_ONE) begin
          // Dwell elapsed: indication released
          next_state = ILD_IDLE;
          next_count = DWELL_RST;
        end else begin
          next_count = count - DWELL_ONE;
        end
      end
      default: begin
        next_state = ILD_IDLE;
        next_count = DWELL_RST;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ILD_IDLE;
      count <= DWELL_RST;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  // Output routing, polarity and delay line
  always_comb begin
    next_hold_first = hold_first;
    next_hold_second = hold_second;
    if (ctrl_i[CTRL_ILV_BIT]) begin
      // Each sub-channel keeps its last detection between its samples
      if (input_enable_i) begin
        next_hold_second = active;
      end else begin
        next_hold_first = active;
      end
      raw[0] = next_hold_first;
      raw[1] = next_hold_second;
    end else begin
      next_hold_first = active;
      next_hold_second = 1'b0;
      raw[0] = active;
      raw[1] = enabled & ~active;
    end
    // Polarity applies to both pins in either mode
    raw = raw ^ {2{ctrl_i[CTRL_POL_BIT]}};
    next_dly[0] = raw;
    for (int i = 1; i < LAT_DEPTH; i++) begin
      next_dly[i] = dly[i-1];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_first <= 1'b0;
      hold_second <= 1'b0;
      for (int i = 0; i < LAT_DEPTH; i++) begin
        dly[i] <= 2'h0;
      end
    end else begin
      hold_first <= next_hold_first;
      hold_second <= next_hold_second;
      for (int i = 0; i < LAT_DEPTH; i++) begin
        dly[i] <= next_dly[i];
      end
    end
  end

  // Tap selects the programmed extra delay
  assign ind_first_o = dly[lat][0];
  assign ind_second_o = dly[lat][1];
endmodule
`default_nettype wire

// ---- hdl/ild_input_level_detector.sv ----
// Input level detector for four ports, two per chip-select half.
// Assumes an 8-bit asynchronous microport and pins sampled on clk_i.
`timescale 1ns/10ps
`default_nettype none
module ild_input_level_detector (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Microport
  input wire logic chip_select_low_half_n_i,
  input wire logic chip_select_high_half_n_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  input wire logic [ild_pkg::EXT_ADDR_W-1:0] addr_i,
  input wire logic [ild_pkg::DATA_W-1:0] data_i,
  output logic [ild_pkg::DATA_W-1:0] data_o,
  output logic data_oe_o,
  // Input ports
  input wire logic [ild_pkg::MANT_W-1:0] port_a_data_i,
  input wire logic [ild_pkg::MANT_W-1:0] port_b_data_i,
  input wire logic [ild_pkg::MANT_W-1:0] port_c_data_i,
  input wire logic [ild_pkg::MANT_W-1:0] port_d_data_i,
  input wire logic port_a_input_enable_i,
  input wire logic port_b_input_enable_i,
  input wire logic port_c_input_enable_i,
  input wire logic port_d_input_enable_i,
  // Level indicator pins
  output logic port_a_indicator_first_o,
  output logic port_a_indicator_second_o,
  output logic port_b_indicator_first_o,
  output logic port_b_indicator_second_o,
  output logic port_c_indicator_first_o,
  output logic port_c_indicator_second_o,
  output logic port_d_indicator_first_o,
  output logic port_d_indicator_second_o
);
  import ild_pkg::*;

  localparam int BUS_W = 2 + EXT_ADDR_W + DATA_W; // Synchronised bus bits
  localparam int PIN_W = NUM_PORTS * (CMP_W + 1); // Synchronised port bits

  // Pin synchronisers; first stage feeds only the second
  logic [BUS_W-1:0] bus_meta, bus_sync;
  logic [PIN_W-1:0] pin_meta, pin_sync;
  logic wr_n_last; // Write strobe one cycle ago
  logic [PIN_W-1:0] pin_raw; // Packed port pins
  logic cs_lo_n, cs_hi_n, wr_n, rd_n; // Synchronised controls
  logic [EXT_ADDR_W-1:0] addr; // Synchronised address
  logic [DATA_W-1:0] wdata; // Synchronised write data

  // Register file, one set per port
  logic [CMP_W-1:0] lower_threshold [NUM_PORTS];
  logic [CMP_W-1:0] upper_threshold [NUM_PORTS];
  logic [DWELL_W-1:0] dwell_time [NUM_PORTS];
  logic [CTRL_W-1:0] gain_range_ctrl [NUM_PORTS];
  logic [CMP_W-1:0] next_lower [NUM_PORTS];
  logic [CMP_W-1:0] next_upper [NUM_PORTS];
  logic [DWELL_W-1:0] next_dwell [NUM_PORTS];
  logic [CTRL_W-1:0] next_ctrl [NUM_PORTS];

  // Microport state
  logic [DATA_W-1:0] sleep_reg, next_sleep_reg; // Sleep register
  logic [CAR_W-1:0] channel_address_pointer, next_car; // Pointer
  logic [DWELL_W-1:0] hold_word, next_hold_word; // Staging word
  logic [DATA_W-1:0] next_data_o;
  logic next_data_oe;

  // Decoded access
  logic wr_pulse; // Falling edge of write strobe
  logic half_sel; // 0 low half, 1 high half
  logic any_cs; // Either half selected
  logic access_ok; // Access bit set and pointer in range
  logic [1:0] port_idx; // Port addressed by pointer
  logic [1:0] sub_off; // Register inside the port set
  logic [DWELL_W-1:0] sel_value; // Register addressed by pointer

  logic [NUM_PORTS-1:0] ind_first, ind_second;

  assign pin_raw = {port_d_input_enable_i, port_d_data_i[MANT_W-1 -: CMP_W],
                    port_c_input_enable_i, port_c_data_i[MANT_W-1 -: CMP_W],
                    port_b_input_enable_i, port_b_data_i[MANT_W-1 -: CMP_W],
                    port_a_input_enable_i, port_a_data_i[MANT_W-1 -: CMP_W]};

  // Two-flop synchronisers for every pin
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bus_meta <= {2'h3, {EXT_ADDR_W{1'b0}}, {DATA_W{1'b0}}};
      bus_sync <= {2'h3, {EXT_ADDR_W{1'b0}}, {DATA_W{1'b0}}};
      pin_meta <= '0;
      pin_sync <= '0;
      wr_n_last <= 1'b1;
    end else begin
      bus_meta <= {wr_n_i, rd_n_i,
                   addr_i, data_i};
      bus_sync <= bus_meta;
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      wr_n_last <= bus_sync[BUS_W-1];
    end
  end

  // Chip selects need their own stage to tell the halves apart
  logic [1:0] cs_meta, cs_sync;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_meta <= 2'h3;
      cs_sync <= 2'h3;
    end else begin
      cs_meta <= {chip_select_high_half_n_i, chip_select_low_half_n_i};
      cs_sync <= cs_meta;
    end
  end

  assign wr_n = bus_sync[BUS_W-1];
  assign rd_n = bus_sync[BUS_W-2];
  assign addr = bus_sync[DATA_W +: EXT_ADDR_W];
  assign wdata = bus_sync[DATA_W-1:0];
  assign cs_lo_n = cs_sync[0];
  assign cs_hi_n = cs_sync[1];
  assign any_cs = ~cs_lo_n | ~cs_hi_n;
  // Low half wins if a host wrongly asserts both selects
  assign half_sel = cs_lo_n;
  assign wr_pulse = wr_n_last & ~wr_n & any_cs;
  // Input port registers are reachable only with the access bit set
  assign access_ok = sleep_reg[SLEEP_ACCESS_BIT] &&
                     (channel_address_pointer < NUM_LOCATIONS);
  assign port_idx = {half_sel, channel_address_pointer[PORT_SEL_BIT]};
  assign sub_off = channel_address_pointer[1:0];

  // Addressed register value, zero-extended
  always_comb begin
    sel_value = DWELL_RST;
    if (access_ok) begin
      case (sub_off)
        LOWER_THRESHOLD_A[1:0]: sel_value = DWELL_W'(lower_threshold[port_idx]);
        UPPER_THRESHOLD_A[1:0]: sel_value = DWELL_W'(upper_threshold[port_idx]);
        DWELL_TIME_A[1:0]: sel_value = dwell_time[port_idx];
        GAIN_RANGE_CTRL_A[1:0]: sel_value = DWELL_W'(gain_range_ctrl[port_idx]);
        default: sel_value = DWELL_RST;
      endcase
    end
  end

  // Microport writes: staging bytes, then commit on the low byte
  always_comb begin
    next_sleep_reg = sleep_reg;
    next_car = channel_address_pointer;
    next_hold_word = hold_word;
    for (int p = 0; p < NUM_PORTS; p++) begin
      next_lower[p] = lower_threshold[p];
      next_upper[p] = upper_threshold[p];
      next_dwell[p] = dwell_time[p];
      next_ctrl[p] = gain_range_ctrl[p];
    end
    if (wr_pulse) begin
      case (addr)
        EXT_DATA2: next_hold_word[DWELL_W-1:2*DATA_W] = wdata[DWELL_W-2*DATA_W-1:0];
        EXT_DATA1: next_hold_word[2*DATA_W-1:DATA_W] = wdata;
        EXT_DATA0: begin
          next_hold_word[DATA_W-1:0] = wdata;
          if (access_ok) begin
            // Commit to the set that the pointer and half select name
            case (sub_off)
              LOWER_THRESHOLD_A[1:0]:
                next_lower[port_idx] = next_hold_word[CMP_W-1:0];
              UPPER_THRESHOLD_A[1:0]:
                next_upper[port_idx] = next_hold_word[CMP_W-1:0];
              DWELL_TIME_A[1:0]:
                next_dwell[port_idx] = next_hold_word;
              GAIN_RANGE_CTRL_A[1:0]:
                next_ctrl[port_idx] = next_hold_word[CTRL_W-1:0];
              default: next_lower[port_idx] = lower_threshold[port_idx];
            endcase
          end
        end
        EXT_SLEEP: next_sleep_reg = wdata;
        EXT_CAR: next_car = wdata;
        default: next_sleep_reg = sleep_reg; // Unmapped: ignored
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sleep_reg <= '0;
      channel_address_pointer <= '0;
      hold_word <= DWELL_RST;
      for (int p = 0; p < NUM_PORTS; p++) begin
        lower_threshold[p] <= THRESH_RST;
        upper_threshold[p] <= THRESH_RST;
        dwell_time[p] <= DWELL_RST;
        gain_range_ctrl[p] <= CTRL_RST;
      end
    end else begin
      sleep_reg <= next_sleep_reg;
      channel_address_pointer <= next_car;
      hold_word <= next_hold_word;
      for (int p = 0; p < NUM_PORTS; p++) begin
        lower_threshold[p] <= next_lower[p];
        upper_threshold[p] <= next_upper[p];
        dwell_time[p] <= next_dwell[p];
        gain_range_ctrl[p] <= next_ctrl[p];
      end
    end
  end

  // Microport read data, registered; reads have no side effects
  always_comb begin
    next_data_oe = ~rd_n & any_cs;
    next_data_o = '0;
    case (addr)
      EXT_DATA0: next_data_o = sel_value[DATA_W-1:0];
      EXT_DATA1: next_data_o = sel_value[2*DATA_W-1:DATA_W];
      EXT_DATA2: next_data_o = DATA_W'(sel_value[DWELL_W-1:2*DATA_W]);
      EXT_SLEEP: next_data_o = sleep_reg;
      EXT_CAR: next_data_o = channel_address_pointer;
      default: next_data_o = '0; // Unmapped reads zero
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_o <= '0;
      data_oe_o <= 1'b0;
    end else begin
      data_o <= next_data_o;
      data_oe_o <= next_data_oe;
    end
  end

  // One detector per port, each with its own settings
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    ild_port_detector u_det (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .mant_i(pin_sync[p*(CMP_W+1) +: CMP_W]),
      .lower_i(lower_threshold[p]),
      .upper_i(upper_threshold[p]),
      .dwell_i(dwell_time[p]),
      .ctrl_i(gain_range_ctrl[p]),
      .input_enable_i(pin_sync[p*(CMP_W+1) + CMP_W]),
      .ind_first_o(ind_first[p]),
      .ind_second_o(ind_second[p])
    );
  end

  assign port_a_indicator_first_o = ind_first[0];
  assign port_a_indicator_second_o = ind_second[0];
  assign port_b_indicator_first_o = ind_first[1];
  assign port_b_indicator_second_o = ind_second[1];
  assign port_c_indicator_first_o = ind_first[2];
  assign port_c_indicator_second_o = ind_second[2];
  assign port_d_indicator_first_o = ind_first[3];
  assign port_d_indicator_second_o = ind_second[3];
endmodule
`default_nettype wire

// ---- verif/ild_input_level_detector_checker.sv ----
// Checker: microport read timing and port A behaviour.
// Assumes port A is set up via the low half, access bit first.
`timescale 1ns/10ps
`default_nettype none
module ild_input_level_detector_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Microport
  input wire logic chip_select_low_half_n_i,
  input wire logic wr_n_i,
  input wire logic rd_n_i,
  input wire logic [ild_pkg::EXT_ADDR_W-1:0] addr_i,
  input wire logic [ild_pkg::DATA_W-1:0] data_i,
  input wire logic data_oe_o,
  // Port A and B pins
  input wire logic [ild_pkg::MANT_W-1:0] port_a_data_i,
  input wire logic port_a_input_enable_i,
  input wire logic port_a_indicator_first_o,
  input wire logic port_a_indicator_second_o,
  input wire logic port_b_indicator_first_o,
  input wire logic port_b_indicator_second_o
);
  import ild_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic wr_q; // Strobe one clock ago
  logic [CAR_W-1:0] ptr, next_ptr; // Snooped pointer
  logic [7:0] s1, next_s1; // Staged middle byte
  logic [3:0] s2, next_s2; // Staged top nibble
  logic [DWELL_W-1:0] dwa, next_dwa; // Port A dwell copy
  logic [CMP_W-1:0] loa, next_loa, upa, next_upa; // Port A thresholds
  logic [CTRL_W-1:0] cta, next_cta; // Port A control copy
  logic [DWELL_W:0] settled, next_settled, low_run, next_low_run; // Saturating
  logic [4:0] ien_run, next_ien_run; // Clocks with enable high
  logic commit, sm; // Commit seen; settled single mode
  logic [CMP_W-1:0] top; // Compared bits
  // Snoop writes on the pin; the design lags, hence the settle count
  always_comb begin
    top = port_a_data_i[MANT_W-1:MANT_W-CMP_W];
    commit = wr_q && !wr_n_i && !chip_select_low_half_n_i && addr_i == EXT_DATA0;
    next_ptr = ptr;
    next_s1 = s1;
    next_s2 = s2;
    next_loa = loa;
    next_upa = upa;
    next_dwa = dwa;
    next_cta = cta;
    if (wr_q && !wr_n_i && !chip_select_low_half_n_i) begin
      case (addr_i)
        EXT_CAR: next_ptr = data_i;
        EXT_DATA1: next_s1 = data_i;
        EXT_DATA2: next_s2 = data_i[3:0];
        default: ;
      endcase
    end
    if (commit) begin
      case (ptr)
        LOWER_THRESHOLD_A: next_loa = {s1[1:0], data_i};
        UPPER_THRESHOLD_A: next_upa = {s1[1:0], data_i};
        DWELL_TIME_A: next_dwa = {s2, s1, data_i};
        GAIN_RANGE_CTRL_A: next_cta = data_i[CTRL_W-1:0];
        default: ;
      endcase
    end
    next_settled = commit ? '0 : settled + {20'h0, ~&settled};
    next_low_run = (top <= loa && top < upa) ? low_run + {20'h0, ~&low_run} : '0;
    next_ien_run = port_a_input_enable_i ? ien_run + {4'h0, ~&ien_run} : 5'h0;
    sm = settled >= 21'h18 && !cta[CTRL_ILV_BIT] && dwa != DWELL_RST;
  end
  // Helper registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {ptr, s1, s2, loa, upa, dwa, cta} <= '0;
      {settled, low_run, ien_run} <= '0;
      wr_q <= 1'b1;
    end else begin
      {ptr, s1, s2, loa, upa} <= {next_ptr, next_s1, next_s2, next_loa, next_upa};
      {dwa, cta, settled} <= {next_dwa, next_cta, next_settled};
      {low_run, ien_run} <= {next_low_run, next_ien_run};
      wr_q <= wr_n_i;
    end
  end
  a_reset_idle: assert property (!$past(rst_n_i) |-> !data_oe_o &&
    !port_a_indicator_first_o && !port_a_indicator_second_o &&
    !port_b_indicator_first_o && !port_b_indicator_second_o)
    else $error("pins active right after reset");
  a_upper_activates: assert property (sm && top >= upa |->
    ##[3:12] port_a_indicator_first_o != cta[CTRL_POL_BIT])
    else $error("upper threshold did not activate port A");
  a_lower_releases: assert property (sm && settled > low_run + 21'h8 &&
    low_run > {1'b0, dwa} + 21'h10 |-> port_a_indicator_first_o == cta[CTRL_POL_BIT])
    else $error("port A still active after dwell");
  a_single_complement: assert property (sm |->
    port_a_indicator_second_o != port_a_indicator_first_o)
    else $error("port A second pin not complement");
  a_disabled_pol: assert property (settled >= 21'h18 && dwa == DWELL_RST |->
    port_a_indicator_first_o == cta[CTRL_POL_BIT] && port_a_indicator_second_o == cta[4])
    else $error("zero dwell left port A pins active");
  a_interleave_steer: assert property (settled >= 21'h18 && cta[3] &&
    dwa != DWELL_RST && ien_run >= 5'h10 |-> $stable(port_a_indicator_first_o))
    else $error("first pin moved while enable high");
  a_oe_from_read: assert property (data_oe_o |->
    !$past(rd_n_i, 2) || !$past(rd_n_i, 3) || !$past(rd_n_i, 4))
    else $error("data driven without read strobe");
  a_oe_released: assert property (rd_n_i [*5] |-> !data_oe_o)
    else $error("data still driven after read");
  c_upper_seen: cover property (sm && port_a_indicator_first_o != cta[CTRL_POL_BIT]);
  c_release_seen: cover property (sm && low_run > {1'b0, dwa} + 21'h10);
  c_steer_seen: cover property (cta[CTRL_ILV_BIT] && ien_run >= 5'h10);
endmodule
bind ild_input_level_detector ild_input_level_detector_checker chk_u (.*);
`default_nettype wire

// ---- verif/ild_adc_model.sv ----
// Front-end model: converter words for the four ports.
// Assumes the bench sets each level; low bits carry noise.
`timescale 1ns/10ps
`default_nettype none
module ild_adc_model (
  // Clock
  input wire logic clk_i,
  // Ten-bit levels, port A lowest
  input wire logic [39:0] level_i,
  // Converter words, port A lowest
  output logic [55:0] mant_o
);
  logic [3:0] noise = 4'h0; // Moves the uncompared bits
  logic [3:0] next_noise; // Next noise
  // Noise step
  always_comb begin
    next_noise = noise + 4'h7;
  end
  // Noise register
  always_ff @(posedge clk_i) begin
    noise <= next_noise;
  end
  // Level in the compared bits, noise below
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      mant_o[14*i +: 14] = {level_i[10*i +: 10], noise ^ i[3:0]};
    end
  end
endmodule
`default_nettype wire

// ---- verif/ild_input_level_detector_tb.sv ----
// Bench for the four-port level detector.
// Assumes the converter model and bound checker.
`timescale 1ns/10ps
`default_nettype none
module ild_input_level_detector_tb;
  import ild_pkg::*;
  logic clk_i, rst_n_i; // Clock and reset
  logic cs_lo_n, cs_hi_n, wr_n, rd_n; // Microport strobes
  logic [EXT_ADDR_W-1:0] addr; // Microport address
  logic [DATA_W-1:0] wdata, rdata; // Microport data
  logic oe; // Read drive enable
  logic [39:0] level; // Levels, port A lowest
  logic [55:0] mant; // Converter words
  logic [3:0] ien; // Steering pins
  logic [7:0] ind; // Port p pins at 2p+1 (first) and 2p
  logic [7:0] rs; // Random state
  logic [7:0] exp_idle; // Expected quiet pins
  logic [CMP_W-1:0] lo, up; // Chosen thresholds
  logic [DWELL_W-1:0] dw; // Chosen dwell
  logic [2:0] lat; // Chosen delay
  int n_mismatch, total_checks;
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  ild_adc_model adc_u (.clk_i(clk_i), .level_i(level), .mant_o(mant));
  ild_input_level_detector dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .chip_select_low_half_n_i(cs_lo_n),
    .chip_select_high_half_n_i(cs_hi_n), .wr_n_i(wr_n), .rd_n_i(rd_n), .addr_i(addr),
    .data_i(wdata), .data_o(rdata), .data_oe_o(oe),
    .port_a_data_i(mant[13:0]), .port_b_data_i(mant[27:14]),
    .port_c_data_i(mant[41:28]), .port_d_data_i(mant[55:42]),
    .port_a_input_enable_i(ien[0]), .port_b_input_enable_i(ien[1]),
    .port_c_input_enable_i(ien[2]), .port_d_input_enable_i(ien[3]),
    .port_a_indicator_first_o(ind[1]), .port_a_indicator_second_o(ind[0]),
    .port_b_indicator_first_o(ind[3]), .port_b_indicator_second_o(ind[2]),
    .port_c_indicator_first_o(ind[5]), .port_c_indicator_second_o(ind[4]),
    .port_d_indicator_first_o(ind[7]), .port_d_indicator_second_o(ind[6]));
  // Random step
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // Single-mode pin pair
  function automatic logic [1:0] pins(input logic act, input logic pol);
    return {act ^ pol, ~act ^ pol};
  endfunction
  // Drives land 5 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #5;
  endtask
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Four clocks each way; select stays so calls abut
  task automatic wr(input logic hi, input logic [2:0] a, input logic [7:0] d);
    cs_lo_n = hi;
    cs_hi_n = ~hi;
    addr = a;
    wdata = d;
    wr_n = 1'b0;
    tick(4);
    wr_n = 1'b1;
    tick(4);
  endtask
  task automatic rd(input logic hi, input logic [2:0] a, input logic [7:0] exp);
    cs_lo_n = hi;
    cs_hi_n = ~hi;
    addr = a;
    rd_n = 1'b0;
    tick(6);
    check("read data", {2'h0, rdata}, {2'h0, exp});
    check("read enable", {9'h0, oe}, 10'h1);
    rd_n = 1'b1;
    cs_lo_n = 1'b1;
    cs_hi_n = 1'b1;
    tick(6);
  endtask
  // Pointer, top bytes; low byte commits
  task automatic prog(input logic [1:0] p, input logic [1:0] o, input logic [19:0] v);
    wr(p[1], EXT_CAR, {5'h0, p[0], o});
    wr(p[1], EXT_DATA2, {4'h0, v[19:16]});
    wr(p[1], EXT_DATA1, v[15:8]);
    wr(p[1], EXT_DATA0, v[7:0]);
  endtask
  // Threshold, delay, dwell walk
  task automatic run(input logic [1:0] p);
    rs = lfsr(rs);
    lo = {1'b0, rs, 1'b0};
    rs = lfsr(rs);
    up = lo + {2'h0, rs} + 10'h020;
    rs = lfsr(rs);
    dw = {16'h0000, rs[3:0]} + 20'h00008;
    lat = rs[6:4];
    if (p == 2'h3) begin
      lo = 10'h3DF;
      up = 10'h3FF;
      lat = 3'h7;
    end
    prog(p, 2'h0, {10'h000, lo});
    prog(p, 2'h1, {10'h000, up});
    prog(p, 2'h2, dw);
    prog(p, 2'h3, {15'h0000, p[0], 1'b0, lat});
    level[10*p +: 10] = up - 10'h001;
    tick(12);
    check("below upper", {8'h0, ind[2*p +: 2]}, {8'h0, pins(1'b0, p[0])});
    level[10*p +: 10] = up;
    tick(lat + 2);
    check("before delay", {8'h0, ind[2*p +: 2]}, {8'h0, pins(1'b0, p[0])});
    tick(4);
    check("upper met", {8'h0, ind[2*p +: 2]}, {8'h0, pins(1'b1, p[0])});
    level[10*p +: 10] = lo;
    tick(dw - 3);
    level[10*p +: 10] = lo + 10'h001;
    tick(3);
    level[10*p +: 10] = lo;
    tick(lat + dw);
    check("reloaded dwell", {8'h0, ind[2*p +: 2]}, {8'h0, pins(1'b1, p[0])});
    tick(10);
    exp_idle[2*p +: 2] = pins(1'b0, p[0]);
    check("dwell over", {2'h0, ind}, {2'h0, exp_idle});
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    tick(30000);
    n_mismatch++;
    results();
  end
  initial begin
    {cs_lo_n, cs_hi_n, wr_n, rd_n, rst_n_i} = 5'h1E;
    {addr, wdata, level, ien, exp_idle} = '0;
    {n_mismatch, total_checks} = '0;
    rs = 8'h55;
    tick(16);
    rst_n_i = 1'b1;
    tick(4);
    check("reset pins", {2'h0, ind}, 10'h0);
    wr(1'b0, EXT_SLEEP, 8'h20);
    for (int p = 0; p < 4; p++) begin
      run(p[1:0]);
    end
    // Port D read back, then unmapped
    wr(1'b1, EXT_CAR, LOWER_THRESHOLD_B);
    rd(1'b1, EXT_DATA0, lo[7:0]);
    rd(1'b1, EXT_DATA1, {6'h00, lo[9:8]});
    rd(1'b1, 3'h5, 8'h00);
    // Interleaved port A
    prog(2'h0, 2'h0, 20'h00010);
    prog(2'h0, 2'h1, 20'h00200);
    prog(2'h0, 2'h2, 20'h00008);
    prog(2'h0, 2'h3, 20'h00008);
    level[9:0] = 10'h3FF;
    tick(10);
    check("steered first", {9'h0, ind[1]}, 10'h1);
    ien[0] = 1'b1;
    tick(10);
    check("steered second", {8'h0, ind[1:0]}, 10'h3);
    level[9:0] = 10'h000;
    tick(24);
    check("first held", {8'h0, ind[1:0]}, 10'h2);
    ien[0] = 1'b0;
    tick(12);
    check("first released", {8'h0, ind[1:0]}, 10'h0);
    // Zero dwell with inverted polarity
    prog(2'h0, 2'h3, 20'h00010);
    prog(2'h0, 2'h2, 20'h00000);
    level[9:0] = 10'h3FF;
    tick(16);
    check("disabled pins", {8'h0, ind[1:0]}, 10'h3);
    results();
  end
endmodule
`default_nettype wire
